// ==== bench/sbsd_checker.sv ====
// checker: bus, rate and irq relations at the block ports
// assumes it is bound to sbsd_top with one clock domain
`default_nettype none
module sbsd_checker (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       sck_out,
	input wire logic       data_out,
	input wire logic       irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  ctl_q;
	logic [7:0]  rate_q;
	logic [10:0] gap_q;
	logic        sck_q;
	wire  [10:0] half = ({8'h00, rate_q[6:4]} + 11'h001) << rate_q[2:0];
	////////////////////////
	// shadow of control and rate, gap since last clock change
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_q  <= 8'h00;
			rate_q <= 8'h00;
			gap_q  <= 11'h000;
			sck_q  <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == 2'h0) ctl_q <= reg_wdata;
			if (reg_wr && reg_addr == 2'h1) rate_q <= reg_wdata;
			gap_q <= (sck_out != sck_q) ? 11'h001 : gap_q + 11'h001;
			sck_q <= sck_out;
		end
	end
	////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	flags_zero_a: assert property (reg_rd && reg_addr == 2'h2 |=>
		(reg_rdata & 8'h4F) == 8'h00) else $error("flags spare bits set");
	rate_back_a: assert property (reg_rd && reg_addr == 2'h1 |=>
		reg_rdata == (rate_q & 8'h77)) else $error("rate readback wrong");
	half_bit_a: assert property ($fell(sck_out) |-> gap_q == half)
		else $error("half bit period wrong");
	slave_quiet_a: assert property (!ctl_q[4] |-> !sck_out)
		else $error("clock out in slave mode");
	tx_irq_a: assert property (reg_rd && reg_addr == 2'h2 && ctl_q[5] && $past(ctl_q[5])
		##1 reg_rdata[5] |-> irq) else $error("transmit irq missing");
	irq_off_a: assert property (!ctl_q[7] && !ctl_q[5] && !$past(ctl_q[7])
		&& !$past(ctl_q[5]) |-> !irq) else $error("irq while disabled");
	shift_hold_a: assert property ($rose(sck_out) |-> $stable(data_out))
		else $error("data moved on sample edge");
	rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
endmodule // sbsd_checker
bind sbsd_top sbsd_checker u_sbsd_checker (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.sck_out(sck_out), .data_out(data_out), .irq(irq));
`default_nettype wire

// ==== bench/sbsd_slave_model.sv ====
// partner: serial slave replying sixteen bits msb first
// assumes clock idles low, sample on rising, shift on falling
`default_nettype none
module sbsd_slave_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        go,
	input  wire logic [15:0] reply,
	input  wire logic        sck,
	input  wire logic        mosi,
	output logic             miso,
	output logic [15:0]      heard,
	output logic [4:0]       bits
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] sr_q;
	logic        sck_q;
	logic        junk_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sr_q   <= 16'h0000;
			sck_q  <= 1'b0;
			junk_q <= 1'b0;
			heard  <= 16'h0000;
			bits   <= 5'h10;
		end else begin
			sck_q  <= sck;
			junk_q <= ~junk_q;
			if (go) begin
				sr_q <= reply;
				bits <= 5'h00;
			end else if (sck && !sck_q) begin
				heard <= {heard[14:0], mosi};
				bits  <= bits + 5'h01;
			end else if (!sck && sck_q) begin
				sr_q <= {sr_q[14:0], 1'b0};
			end
		end
	end
	// outside a frame the line toggles every cycle
	assign miso = (bits < 5'h10) ? sr_q[15] : junk_q;
endmodule // sbsd_slave_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// testbench: register tasks, transfers, overrun, mode fault and slave mode
// assumes sbsd_top, its checker and sbsd_slave_model are compiled
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, ss_in_n = 1, go = 0;
	logic [1:0]  reg_addr = 2'h0;
	logic [7:0]  reg_wdata = 8'h00, v, reg_rdata;
	logic        sck_out, data_out, irq, miso;
	logic [15:0] heard;
	logic [4:0]  bits;
	logic [7:0]  rt [2] = '{8'h11, 8'h32};
	logic        sck_pin = 0, mosi_pin = 0;
	logic [7:0]  so = 8'h00;
	localparam logic [7:0] SLV_RX = 8'h69;
	int          bad_count = 0, num_checks = 0, cyc = 0;
	always #25 clk = ~clk;
	sbsd_top u_sbsd_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck_in(sck_pin),
		.miso_in(miso), .mosi_in(mosi_pin), .ss_in_n(ss_in_n), .sck_out(sck_out),
		.data_out(data_out), .irq(irq));
	sbsd_slave_model u_sbsd_slave_model (.clk(clk), .rst_n(rst_n), .go(go), .reply(16'h3CA9),
		.sck(sck_out), .mosi(data_out), .miso(miso), .heard(heard), .bits(bits));
	////////////////////////
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [1:0] a);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		v = reg_rdata;
		@(posedge clk);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		wr(2'h0, 8'h10);
		wr(2'h3, 8'h5A);
		repeat (60) @(posedge clk);
		chk("frame bits", bits, 16);
		wr(2'h2, 8'hFF);
		rd(2'h2);
		chk("flags", v, 8'h20);
		rd(2'h3);
		chk("data", v, 8'h00);
		wr(2'h1, 8'hFF);
		rd(2'h1);
		chk("rate", v, 8'h77);
		$display("test registers done");
		foreach (rt[i]) begin
			wr(2'h1, rt[i]);
			wr(2'h0, 8'h30);
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			rd(2'h2);
			chk("flags", v, 8'h20);
			wr(2'h3, 8'hC3);
			@(posedge clk);
			rd(2'h2);
			chk("flags", v, 8'h20);
			wr(2'h3, 8'h5E);
			rd(2'h2);
			chk("flags", v, 8'h00);
			chk("irq", irq, 0);
			for (int k = 0; k < 3000 && bits != 5'h10; k++) @(posedge clk);
			repeat (40) @(posedge clk);
			rd(2'h2);
			chk("flags", v, 8'hA0);
			chk("irq", irq, 1);
			chk("sent", heard, 16'hC35E);
			rd(2'h3);
			chk("data", v, 8'h3C);
			rd(2'h2);
			chk("flags", v, 8'h20);
			$display("test transfer done");
		end
		for (int i = 0; i < 2; i++) begin
			wr(2'h0, i ? 8'h94 : 8'h96);
			ss_in_n <= 1'b0;
			repeat (6) @(posedge clk);
			rd(2'h2);
			chk("flags", v, i ? 8'h30 : 8'h20);
			ss_in_n <= 1'b1;
			repeat (4) @(posedge clk);
		end
		chk("irq", irq, 1);
		wr(2'h0, 8'h94);
		rd(2'h2);
		chk("flags", v, 8'h20);
		chk("irq", irq, 0);
		$display("test mode fault done");
		wr(2'h0, 8'h00);
		rd(2'h2);
		chk("flags", v, 8'h20);
		wr(2'h3, 8'hA5);
		ss_in_n <= 1'b0;
		repeat (4) @(posedge clk);
		for (int b = 7; b >= 0; b--) begin
			mosi_pin <= SLV_RX[b];
			repeat (4) @(posedge clk);
			so = {so[6:0], data_out};
			sck_pin <= 1'b1;
			repeat (4) @(posedge clk);
			sck_pin <= 1'b0;
		end
		repeat (8) @(posedge clk);
		ss_in_n <= 1'b1;
		chk("slave out", so, 8'hA5);
		rd(2'h2);
		chk("flags", v, 8'hA0);
		rd(2'h3);
		chk("slave in", v, SLV_RX);
		chk("irq", irq, 0);
		$display("test slave done");
		finish_test();
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			finish_test();
		end
	end
endmodule // tb_top
`default_nettype wire

// ==== hdl/sbsd_pkg.sv ====
// constants, field layout and state type of the serial rate, flag and data block
// assumes a single 20 MHz bus clock and byte-wide register access
`default_nettype none
package sbsd_pkg;
	localparam logic [1:0] ADDR_CTRL1 = 2'h0;
	localparam logic [1:0] ADDR_RATE  = 2'h1;
	localparam logic [1:0] ADDR_FLAGS = 2'h2;
	localparam logic [1:0] ADDR_DATA  = 2'h3;
	localparam int CTRL_GIE   = 7;
	localparam int CTRL_TIE   = 5;
	localparam int CTRL_MASTER_SELECT  = 4;
	localparam int CTRL_FDEN  = 2;
	localparam int CTRL_SELECT_OUTPUT_ENABLE  = 1;
	localparam logic [7:0] CTRL_MASK = 8'hB6;
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam int RATE_PRE_LO = 4;
	localparam int RATE_DIV_LO = 0;
	localparam logic [7:0] RATE_MASK = 8'h77;
	localparam logic [7:0] RATE_RST  = 8'h00;
	localparam int FLAG_RXF  = 7;
	localparam int FLAG_TXE  = 5;
	localparam int FLAG_MODE_FAULT_FLAG = 4;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [3:0] LAST_EDGE = 4'hF;
	typedef enum logic {
		SH_IDLE = 1'b0,
		SH_RUN  = 1'b1
	} sbsd_shift_e;
endpackage
`default_nettype wire

// ==== hdl/sbsd_rate_gen.sv ====
// bit rate generator: prescaler then power of two divider, half-bit tick out
// assumes synchronous reset release and same-clock inputs
`default_nettype none
module sbsd_rate_gen (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       run,
	input  wire logic [2:0] pre_sel,
	input  wire logic [2:0] div_sel,
	output logic            half_tick
);
	logic [2:0] pre_q;
	logic [7:0] div_q;
	wire        pre_end = (pre_q == pre_sel);
	wire  [7:0] div_lim = (8'h01 << div_sel) - 8'h01;
	wire        div_end = pre_end && (div_q == div_lim);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= 3'h0;
			div_q <= 8'h00;
			half_tick <= 1'b0;
		end else if (!run) begin
			pre_q <= 3'h0;
			div_q <= 8'h00;
			half_tick <= 1'b0;
		end else begin
			pre_q <= pre_end ? 3'h0 : pre_q + 3'h1;
			if (pre_end)
				div_q <= div_end ? 8'h00 : div_q + 8'h01;
			half_tick <= div_end;
		end
	end
endmodule // sbsd_rate_gen
`default_nettype wire

// ==== hdl/sbsd_shifter.sv ====
// eight bit shifter: odd edges sample, even edges shift, sixteen edges a byte
// assumes edge pulses come from the rate generator or a synchronised clock pin
`default_nettype none
module sbsd_shifter (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       load,
	input  wire logic [7:0] load_data,
	input  wire logic       edge_pulse,
	input  wire logic       in_bit,
	input  wire logic       drive_clk,
	output logic            busy,
	output logic            done,
	output logic [7:0]      rx_data,
	output logic            out_bit,
	output logic            sck
);
	sbsd_pkg::sbsd_shift_e st_q;
	logic [7:0] sr_q;
	logic [3:0] cnt_q;
	logic       samp_q;
	wire        run_edge = (st_q == sbsd_pkg::SH_RUN) && edge_pulse;
	wire  [7:0] next_sr  = {sr_q[6:0], samp_q};

	assign busy = (st_q == sbsd_pkg::SH_RUN);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= sbsd_pkg::SH_IDLE;
			sr_q <= 8'h00;
			cnt_q <= 4'h0;
			samp_q <= 1'b0;
			done <= 1'b0;
			rx_data <= 8'h00;
			out_bit <= 1'b0;
			sck <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load) begin
				st_q <= sbsd_pkg::SH_RUN;
				sr_q <= load_data;
				out_bit <= load_data[7];
				cnt_q <= 4'h0;
				sck <= 1'b0;
			end else if (run_edge) begin
				cnt_q <= cnt_q + 4'h1;
				sck <= drive_clk & ~sck;
				if (!cnt_q[0])
					samp_q <= in_bit;
				else begin
					sr_q <= next_sr;
					out_bit <= sr_q[6];
				end
				if (cnt_q == sbsd_pkg::LAST_EDGE) begin
					st_q <= sbsd_pkg::SH_IDLE;
					rx_data <= next_sr;
					done <= 1'b1;
				end
			end
		end
	end
endmodule // sbsd_shifter
`default_nettype wire

// ==== hdl/sbsd_top.sv ====
// serial port rate, flag and data registers with double-buffered shifter
// assumes one 20 MHz clock; pins arrive asynchronously and are synchronised
`default_nettype none
module sbsd_top (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	input  wire logic       sck_in,
	input  wire logic       miso_in,
	input  wire logic       mosi_in,
	input  wire logic       ss_in_n,
	output logic            sck_out,
	output logic            data_out,
	output logic            irq
);
	////////////////////////////////////////////////////////////////
	// reset release
	logic rst_m_q;
	logic rst_s_n;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_m_q <= 1'b0;
			rst_s_n <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_s_n <= rst_m_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [3:0] pin_m_q;
	logic [3:0] pin_s_q;
	logic       ss_d1_q;
	logic       sck_d1_q;

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			pin_m_q <= 4'h8;
			pin_s_q <= 4'h8;
			ss_d1_q <= 1'b1;
			sck_d1_q <= 1'b0;
		end else begin
			pin_m_q <= {ss_in_n, sck_in, miso_in, mosi_in};
			pin_s_q <= pin_m_q;
			ss_d1_q <= pin_s_q[3];
			sck_d1_q <= pin_s_q[2];
		end
	end

	wire ss_s   = pin_s_q[3];
	wire sck_s  = pin_s_q[2];
	wire miso_s = pin_s_q[1];
	wire mosi_s = pin_s_q[0];
	wire ss_fall  = ss_d1_q & ~ss_s;
	wire sck_edge = sck_d1_q ^ sck_s;

	////////////////////////////////////////////////////////////////
	// registers
	logic [7:0] ctrl_q;
	logic [7:0] rate_q;
	logic [7:0] txbuf_q;
	logic [7:0] rxbuf_q;
	logic       tx_full_q;
	logic       rxf_q;
	logic       txe_q;
	logic       mode_fault_flag_q;
	logic       rxf_arm_q;
	logic       txe_arm_q;
	logic       mode_fault_flag_arm_q;
	logic [7:0] rdata_q;
	logic       irq_q;

	wire wr_ctrl  = reg_wr && (reg_addr == sbsd_pkg::ADDR_CTRL1);
	wire wr_rate  = reg_wr && (reg_addr == sbsd_pkg::ADDR_RATE);
	wire wr_data  = reg_wr && (reg_addr == sbsd_pkg::ADDR_DATA);
	wire rd_flags = reg_rd && (reg_addr == sbsd_pkg::ADDR_FLAGS);
	wire rd_data  = reg_rd && (reg_addr == sbsd_pkg::ADDR_DATA);

	wire master  = ctrl_q[sbsd_pkg::CTRL_MASTER_SELECT];
	wire fd_en   = ctrl_q[sbsd_pkg::CTRL_FDEN];
	wire ss_oe   = ctrl_q[sbsd_pkg::CTRL_SELECT_OUTPUT_ENABLE];
	wire gie     = ctrl_q[sbsd_pkg::CTRL_GIE];
	wire tie     = ctrl_q[sbsd_pkg::CTRL_TIE];

	wire [7:0] flags_view = {rxf_q, 1'b0, txe_q, mode_fault_flag_q, 4'h0};

	////////////////////////////////////////////////////////////////
	// shifter and rate clock
	logic       half_tick;
	logic       sh_busy;
	logic       sh_done;
	logic [7:0] sh_rx;
	logic       sh_out;
	logic       sh_sck;

	wire tx_take   = wr_data && txe_arm_q && txe_q;
	wire move_tx   = tx_full_q && (!sh_busy || sh_done);
	wire edge_sel  = master ? half_tick : (sck_edge & ~ss_s);
	wire in_sel    = master ? miso_s : mosi_s;

	sbsd_rate_gen u_rate (
		.clk       (clk),
		.rst_n     (rst_s_n),
		.run       (master && sh_busy),
		.pre_sel   (rate_q[sbsd_pkg::RATE_PRE_LO +: 3]),
		.div_sel   (rate_q[sbsd_pkg::RATE_DIV_LO +: 3]),
		.half_tick (half_tick)
	);

	sbsd_shifter u_shift (
		.clk        (clk),
		.rst_n      (rst_s_n),
		.load       (move_tx),
		.load_data  (txbuf_q),
		.edge_pulse (edge_sel),
		.in_bit     (in_sel),
		.drive_clk  (master),
		.busy       (sh_busy),
		.done       (sh_done),
		.rx_data    (sh_rx),
		.out_bit    (sh_out),
		.sck        (sh_sck)
	);

	////////////////////////////////////////////////////////////////
	// flag next values; hardware set wins over clear, but RXF only sets while it is clear
	wire rxf_clr  = rd_data && rxf_arm_q;
	wire rxf_set  = sh_done && !rxf_q;
	wire txe_clr  = tx_take;
	wire mode_fault_flag_set = ss_fall && master && fd_en && !ss_oe;
	wire mode_fault_flag_clr = wr_ctrl && mode_fault_flag_arm_q;

	wire rxf_d  = rxf_set | (rxf_q & ~rxf_clr);
	wire txe_d  = move_tx | (txe_q & ~txe_clr);
	wire mode_fault_flag_d = mode_fault_flag_set | (mode_fault_flag_q & ~mode_fault_flag_clr);

	wire [7:0] rd_mux = (reg_addr == sbsd_pkg::ADDR_CTRL1) ? ctrl_q :
		(reg_addr == sbsd_pkg::ADDR_RATE) ? rate_q :
		(reg_addr == sbsd_pkg::ADDR_FLAGS) ? flags_view : rxbuf_q;

	wire irq_d = (tie & txe_q) | (gie & (rxf_q | mode_fault_flag_q));

	////////////////////////////////////////////////////////////////
	// control and rate registers
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			ctrl_q <= sbsd_pkg::CTRL_RST;
			rate_q <= sbsd_pkg::RATE_RST;
		end else begin
			if (wr_ctrl)
				ctrl_q <= reg_wdata & sbsd_pkg::CTRL_MASK;
			if (wr_rate)
				rate_q <= reg_wdata & sbsd_pkg::RATE_MASK;
		end
	end

	////////////////////////////////////////////////////////////////
	// transmit and receive buffers
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			txbuf_q <= sbsd_pkg::DATA_RST;
			rxbuf_q <= sbsd_pkg::DATA_RST;
			tx_full_q <= 1'b0;
		end else begin
			if (tx_take)
				txbuf_q <= reg_wdata;
			if (rxf_set)
				rxbuf_q <= sh_rx;
			tx_full_q <= tx_take | (tx_full_q & ~move_tx);
		end
	end

	////////////////////////////////////////////////////////////////
	// flags and their clear arming
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			rxf_q <= 1'b0;
			txe_q <= 1'b1;
			mode_fault_flag_q <= 1'b0;
			rxf_arm_q <= 1'b0;
			txe_arm_q <= 1'b0;
			mode_fault_flag_arm_q <= 1'b0;
		end else begin
			rxf_q <= rxf_d;
			txe_q <= txe_d;
			mode_fault_flag_q <= mode_fault_flag_d;
			rxf_arm_q <= rxf_d & ((rd_flags & rxf_q) | (rxf_arm_q & ~rxf_clr));
			txe_arm_q <= txe_d & ((rd_flags & txe_q) | (txe_arm_q & ~txe_clr));
			mode_fault_flag_arm_q <= mode_fault_flag_d & ((rd_flags & mode_fault_flag_q) | (mode_fault_flag_arm_q & ~mode_fault_flag_clr));
		end
	end

	////////////////////////////////////////////////////////////////
	// read data and outputs
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			rdata_q <= 8'h00;
			irq_q <= 1'b0;
		end else begin
			rdata_q <= reg_rd ? rd_mux : 8'h00;
			irq_q <= irq_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq = irq_q;
	assign sck_out = sh_sck;
	assign data_out = sh_out;
endmodule // sbsd_top
`default_nettype wire
